/* hw/phy_led_and_test_logic.sv */
`timescale 1ns/1ns
`default_nettype none
module phy_led_and_test_logic #(
  parameter int PULSE_CYC = phy_test_pkg::PULSE_CYC  // Cycles per 5 kHz period
) (
  input  wire logic                    clk_sys,         // System clock
  input  wire logic                    rst,             // Synchronous reset
  input  wire phy_test_pkg::led_cfg_s  led_cfg [4],     // Per-pin indicator setup
  input  wire logic                    led_invert,      // Flip asserted level
  input  wire logic                    led_pulsing_en,  // 5 kHz power-save pulsing
  input  wire logic                    act_tx_only,     // Activity mode shows tx only
  input  wire logic                    link_up,         // Link established
  input  wire logic [1:0]              link_speed,      // 0:10 1:100 2:1000
  input  wire logic                    full_duplex,     // Duplex of current link
  input  wire logic                    collision,       // Collision seen
  input  wire logic                    an_fault,        // Auto-negotiation fault
  output logic [3:0]                   indicator_outputs, // Indicator pins
  input  wire phy_test_pkg::stream_s   mac_tx,          // From MAC
  output phy_test_pkg::stream_s        mac_rx,          // To MAC
  input  wire phy_test_pkg::stream_s   media_rx,        // From partner
  output phy_test_pkg::stream_s        media_tx,        // To partner
  input  wire logic                    gen_en,          // Generator owns transmit
  input  wire logic                    gen_run_set,     // Pulse: start generator
  input  wire logic                    gen_run_clr,     // Pulse: stop generator
  input  wire phy_test_pkg::gen_cfg_s  gen_cfg,         // Generator frame setup
  output logic                         gen_run,         // Run bit state
  input  wire logic                    far_loop_en,     // Far-end loopback
  input  wire logic                    dig_loop_en,     // Near-end loopback
  input  wire logic                    rd_good,         // Pulse: read good count
  input  wire logic                    rd_bad,          // Pulse: read bad count
  input  wire logic                    rd_active,       // Pulse: read active bit
  output logic [13:0]                  good_count,      // Good packet count
  output logic [7:0]                   bad_count,       // Bad CRC or receive-error packet count
  output logic                         count_active     // Packet received flag
);

  // ****************************************
  // Shared time base
  // ****************************************
  logic [13:0] pre_cnt, next_pre_cnt;
  logic [2:0]  tick_cnt, next_tick_cnt;
  logic [4:0]  unit_cnt, next_unit_cnt;
  logic [3:0]  slot, next_slot;
  logic        ms_tick, unit_tick, pulse_on;

  // Five 5 kHz periods make a 1 ms tick, then 25 ms blink slots
  always_comb begin
    ms_tick       = (pre_cnt == 14'(PULSE_CYC - 1)) && (tick_cnt == 3'(phy_test_pkg::PULSE_PER_TICK - 1));
    unit_tick     = ms_tick && (unit_cnt == 5'(phy_test_pkg::UNIT_MS - 1));
    pulse_on      = pre_cnt < 14'(PULSE_CYC * phy_test_pkg::PULSE_DUTY_PCT / 100);
    next_pre_cnt  = (pre_cnt == 14'(PULSE_CYC - 1)) ? 14'h0 : pre_cnt + 14'h1;
    next_tick_cnt = tick_cnt;
    if (pre_cnt == 14'(PULSE_CYC - 1)) begin
      next_tick_cnt = ms_tick ? 3'h0 : tick_cnt + 3'h1;
    end
    next_unit_cnt = ms_tick ? (unit_tick ? 5'h0 : unit_cnt + 5'h1) : unit_cnt;
    next_slot     = unit_tick ? slot + 4'h1 : slot;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_cnt  <= 14'h0;
      tick_cnt <= 3'h0;
      unit_cnt <= 5'h0;
      slot     <= 4'h0;
    end else begin
      pre_cnt  <= next_pre_cnt;
      tick_cnt <= next_tick_cnt;
      unit_cnt <= next_unit_cnt;
      slot     <= next_slot;
    end
  end

  // ****************************************
  // Indicator pins
  // ****************************************
  logic s10, s100, s1000, act_evt;
  assign s10     = link_up && (link_speed == phy_test_pkg::SPD_10);
  assign s100    = link_up && (link_speed == phy_test_pkg::SPD_100);
  assign s1000   = link_up && (link_speed == phy_test_pkg::SPD_1000);
  assign act_evt = media_tx.en || (!act_tx_only && media_rx.en);

  for (genvar p = 0; p < 4; p++) begin : g_pin
    phy_test_pkg::stretch_e st, next_st;
    logic [8:0] st_cnt, next_st_cnt;
    logic       recent, next_recent, level, next_level;
    logic       prim, sec, sec_mode, shown, pattern;

    // Primary status and secondary event for the chosen mode
    always_comb begin
      prim     = 1'b0;
      sec      = 1'b0;
      sec_mode = 1'b0;
      unique case (led_cfg[p].mode)
        phy_test_pkg::MODE_LINK_ACT:   begin prim = link_up;       sec = act_evt; end
        phy_test_pkg::MODE_L1000_ACT:  begin prim = s1000;         sec = act_evt; end
        phy_test_pkg::MODE_L100_ACT:   begin prim = s100;          sec = act_evt; end
        phy_test_pkg::MODE_L10_ACT:    begin prim = s10;           sec = act_evt; end
        phy_test_pkg::MODE_L100_1000:  begin prim = s100 | s1000;  sec = act_evt; end
        phy_test_pkg::MODE_L10_1000:   begin prim = s10 | s1000;   sec = act_evt; end
        phy_test_pkg::MODE_L10_100:    begin prim = s10 | s100;    sec = act_evt; end
        phy_test_pkg::MODE_DUPLEX_COL: begin
          prim = link_up && full_duplex;
          sec  = link_up && !full_duplex && collision;
        end
        phy_test_pkg::MODE_COLLISION:  begin sec = collision; sec_mode = 1'b1; end
        phy_test_pkg::MODE_ACTIVITY:   begin sec = act_evt;   sec_mode = 1'b1; end
        phy_test_pkg::MODE_AN_FAULT:   prim = an_fault;
        phy_test_pkg::MODE_FORCE_ON:   prim = 1'b1;
        default:                       prim = 1'b0;
      endcase
      // Event modes always show events; others only combined
      if (!sec_mode && (led_cfg[p].combine_dis || !prim)) begin
        sec = 1'b0;
      end
    end

    // Stretch sequencer and blink activity memory
    always_comb begin
      next_st     = st;
      next_st_cnt = st_cnt;
      next_recent = recent;
      if (unit_tick) begin
        next_recent = 1'b0;
      end
      if (sec) begin
        next_recent = 1'b1; // Event in the clearing cycle still counts
      end
      unique case (st)
        phy_test_pkg::S_IDLE: begin
          if (sec) begin
            next_st     = phy_test_pkg::S_ON;
            next_st_cnt = 9'(phy_test_pkg::STRETCH_MS << led_cfg[p].rate);
          end
        end
        phy_test_pkg::S_ON, phy_test_pkg::S_OFF: begin
          if (ms_tick) begin
            next_st_cnt = st_cnt - 9'h1;
            if (st_cnt == 9'h1) begin
              next_st     = (st == phy_test_pkg::S_ON) ? phy_test_pkg::S_OFF : phy_test_pkg::S_IDLE;
              next_st_cnt = 9'(phy_test_pkg::STRETCH_MS << led_cfg[p].rate);
            end
          end
        end
        default: next_st = phy_test_pkg::S_IDLE;
      endcase
      // Blink slot bit: rate 0 toggles every 200 ms, rate 3 every 25 ms
      pattern    = led_cfg[p].stretch_en ? (st == phy_test_pkg::S_ON)
                   : (recent && !slot[3 - led_cfg[p].rate]);
      shown      = (sec || recent || st != phy_test_pkg::S_IDLE) && (sec_mode || !led_cfg[p].combine_dis)
                   && (sec_mode || prim) && (st != phy_test_pkg::S_IDLE || recent) ? pattern : prim;
      next_level = shown && (!led_pulsing_en || pulse_on);
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        st     <= phy_test_pkg::S_IDLE;
        st_cnt <= 9'h0;
        recent <= 1'b0;
        level  <= 1'b0;
      end else begin
        st     <= next_st;
        st_cnt <= next_st_cnt;
        recent <= next_recent;
        level  <= next_level;
      end
    end

    assign indicator_outputs[p] = level ^ !led_invert;
  end

  // ****************************************
  // CRC helper
  // ****************************************
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ phy_test_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ****************************************
  // Packet generator
  // ****************************************
  phy_test_pkg::gen_state_e gst, next_gst;
  logic [11:0] gcnt, next_gcnt;
  logic [31:0] gcrc, next_gcrc;
  logic [24:0] gpkts, next_gpkts;
  logic        next_gen_run;
  phy_test_pkg::stream_s gout;

  // Byte sequencer; CRC runs over address, length and payload only
  always_comb begin
    next_gst     = gst;
    next_gcnt    = gcnt + 12'h1;
    next_gcrc    = gcrc;
    next_gpkts   = gpkts;
    next_gen_run = gen_run;
    gout         = '{en: 1'b1, er: 1'b0, data: phy_test_pkg::PREAMBLE};
    unique case (gst)
      phy_test_pkg::G_IDLE: begin
        gout.en   = 1'b0;
        next_gcnt = 12'h0;
        next_gcrc = 32'hffffffff;
        if (gen_run) next_gst = phy_test_pkg::G_PRE;
      end
      phy_test_pkg::G_PRE: begin
        if (gcnt == 12'(phy_test_pkg::PRE_LEN)) begin
          gout.data = phy_test_pkg::SFD;
          next_gst  = phy_test_pkg::G_DA;
          next_gcnt = 12'h0;
        end
      end
      phy_test_pkg::G_DA, phy_test_pkg::G_SA, phy_test_pkg::G_LEN, phy_test_pkg::G_DATA: begin
        unique case (gst)
          phy_test_pkg::G_DA:  gout.data = gen_cfg.dst_addr[8'(47 - 8 * gcnt) -: 8];
          phy_test_pkg::G_SA:  gout.data = gen_cfg.src_addr[8'(47 - 8 * gcnt) -: 8];
          phy_test_pkg::G_LEN: gout.data = gcnt[0] ? gen_cfg.size[7:0] : {4'h0, gen_cfg.size[11:8]};
          default: gout.data = gen_cfg.pat_incr ? gcnt[7:0] : gen_cfg.pattern;
        endcase
        next_gcrc = crc_step(gcrc, gout.data);
        if ((gst == phy_test_pkg::G_LEN && gcnt == 12'h1)
            || (gst == phy_test_pkg::G_DATA && gcnt == gen_cfg.size - 12'h1)
            || (gst < phy_test_pkg::G_LEN && gcnt == 12'h5)) begin
          next_gst  = phy_test_pkg::gen_state_e'(gst + 3'h1);
          next_gcnt = 12'h0;
          if (gst == phy_test_pkg::G_LEN && gen_cfg.size == 12'h0) next_gst = phy_test_pkg::G_FCS;
        end
      end
      phy_test_pkg::G_FCS: begin
        gout.data = gen_cfg.bad_fcs ? gcrc[7:0] : ~gcrc[7:0];
        next_gcrc = gcrc >> 8;
        if (gcnt == 12'h3) begin
          next_gst   = phy_test_pkg::G_GAP;
          next_gcnt  = 12'h0;
          next_gpkts = gpkts + 25'h1;
          if (!gen_cfg.continuous && gpkts == 25'(phy_test_pkg::GEN_PKT_LIMIT - 1)) begin
            next_gen_run = 1'b0;
            next_gpkts   = 25'h0;
          end
        end
      end
      phy_test_pkg::G_GAP: begin
        gout.en = 1'b0;
        if (gcnt >= {4'h0, gen_cfg.gap}) next_gst = phy_test_pkg::G_IDLE;
      end
      default: next_gst = phy_test_pkg::G_IDLE;
    endcase
    if (gen_run_clr) next_gen_run = 1'b0;
    if (gen_run_set) begin
      next_gen_run = 1'b1;
      next_gpkts   = 25'h0;
    end
    if (!gen_en) next_gst = phy_test_pkg::G_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gst     <= phy_test_pkg::G_IDLE;
      gcnt    <= 12'h0;
      gcrc    <= 32'hffffffff;
      gpkts   <= 25'h0;
      gen_run <= 1'b0;
    end else begin
      gst     <= next_gst;
      gcnt    <= next_gcnt;
      gcrc    <= next_gcrc;
      gpkts   <= next_gpkts;
      gen_run <= next_gen_run;
    end
  end

  // ****************************************
  // Data paths and receive counters
  // ****************************************
  phy_test_pkg::stream_s next_mac_rx, next_media_tx;
  logic        in_frame, next_in_frame, rx_err, next_rx_err;
  logic [31:0] rcrc, next_rcrc;
  logic [13:0] next_good;
  logic [7:0]  next_bad;
  logic        next_active, done, ok;

  // Loopback has priority over the generator, near end over far end
  always_comb begin
    next_media_tx = mac_tx;
    if (gen_en) next_media_tx = gout;
    if (far_loop_en) next_media_tx = media_rx;
    if (dig_loop_en) next_media_tx = '0;
    next_mac_rx = dig_loop_en ? mac_tx : media_rx;
  end

  // Frame check on media receive, one counter per frame
  always_comb begin
    next_in_frame = in_frame;
    next_rx_err   = rx_err;
    next_rcrc     = rcrc;
    done          = in_frame && !media_rx.en;
    ok            = (rcrc == phy_test_pkg::CRC_RESIDUE) && !rx_err;
    if (media_rx.en && !in_frame && media_rx.data == phy_test_pkg::SFD) begin
      next_in_frame = 1'b1;
      next_rx_err   = media_rx.er;
      next_rcrc     = 32'hffffffff;
    end else if (media_rx.en && in_frame) begin
      next_rcrc   = crc_step(rcrc, media_rx.data);
      next_rx_err = rx_err || media_rx.er;
    end else if (done) begin
      next_in_frame = 1'b0;
    end
    // Read clears first so a frame ending in the same cycle is kept
    next_good   = rd_good ? 14'h0 : good_count;
    next_bad    = rd_bad ? 8'h0 : bad_count;
    next_active = rd_active ? 1'b0 : count_active;
    if (done) begin
      next_active = 1'b1;
      if (ok) begin
        next_good = (next_good == phy_test_pkg::GOOD_MAX) ? 14'h0 : next_good + 14'h1;
      end else if (next_bad != phy_test_pkg::BAD_MAX) begin
        next_bad = next_bad + 8'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mac_rx       <= '0;
      media_tx     <= '0;
      in_frame     <= 1'b0;
      rx_err       <= 1'b0;
      rcrc         <= 32'hffffffff;
      good_count   <= 14'h0;
      bad_count    <= 8'h0;
      count_active <= 1'b0;
    end else begin
      mac_rx       <= next_mac_rx;
      media_tx     <= next_media_tx;
      in_frame     <= next_in_frame;
      rx_err       <= next_rx_err;
      rcrc         <= next_rcrc;
      good_count   <= next_good;
      bad_count    <= next_bad;
      count_active <= next_active;
    end
  end

endmodule : phy_led_and_test_logic
`default_nettype wire

/* hw/phy_test_pkg.sv */
package phy_test_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int CLK_HZ         = 50_000_000;
  localparam int PULSE_HZ       = 5_000;
  localparam int PULSE_DUTY_PCT = 20;
  localparam int PULSE_CYC      = CLK_HZ / PULSE_HZ;
  localparam int PULSE_ON_CYC   = PULSE_CYC * PULSE_DUTY_PCT / 100;
  localparam int TICK_US        = 1_000;
  localparam int PULSE_PER_TICK = TICK_US * PULSE_HZ / 1_000_000;
  localparam int UNIT_MS        = 25;        // Blink slot, 1/16 of 2.5 Hz period
  localparam int STRETCH_MS     = 50;        // Shortest stretch, doubled per rate step

  // ****************************************
  // Counters and frame constants
  // ****************************************
  localparam int          GEN_PKT_LIMIT = 30_000_000;
  localparam logic [13:0] GOOD_MAX      = 14'h270f;
  localparam logic [7:0]  BAD_MAX       = 8'hff;
  localparam logic [7:0]  PREAMBLE      = 8'h55;
  localparam logic [7:0]  SFD           = 8'hd5;
  localparam logic [31:0] CRC_POLY      = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hdebb20e3;
  localparam logic [2:0]  PRE_LEN       = 3'h7;

  // ****************************************
  // Indicator modes and speed codes
  // ****************************************
  localparam logic [3:0] MODE_LINK_ACT    = 4'h0;
  localparam logic [3:0] MODE_L1000_ACT   = 4'h1;
  localparam logic [3:0] MODE_L100_ACT    = 4'h2;
  localparam logic [3:0] MODE_L10_ACT     = 4'h3;
  localparam logic [3:0] MODE_L100_1000   = 4'h4;
  localparam logic [3:0] MODE_L10_1000    = 4'h5;
  localparam logic [3:0] MODE_L10_100     = 4'h6;
  localparam logic [3:0] MODE_DUPLEX_COL  = 4'h8;
  localparam logic [3:0] MODE_COLLISION   = 4'h9;
  localparam logic [3:0] MODE_ACTIVITY    = 4'ha;
  localparam logic [3:0] MODE_AN_FAULT    = 4'hc;
  localparam logic [3:0] MODE_FORCE_OFF   = 4'he;
  localparam logic [3:0] MODE_FORCE_ON    = 4'hf;
  localparam logic [1:0] SPD_10           = 2'h0;
  localparam logic [1:0] SPD_100          = 2'h1;
  localparam logic [1:0] SPD_1000         = 2'h2;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [7:0] data;
  } stream_s;

  typedef struct packed {
    logic [3:0] mode;
    logic       combine_dis;
    logic       stretch_en;
    logic [1:0] rate;
  } led_cfg_s;

  typedef struct packed {
    logic [47:0] dst_addr;
    logic [47:0] src_addr;
    logic [11:0] size;        // Payload bytes
    logic [7:0]  gap;         // Idle bytes between frames
    logic        bad_fcs;
    logic        continuous;  // 0: stop after the packet limit
    logic        pat_incr;    // Incrementing payload instead of fixed byte
    logic [7:0]  pattern;
  } gen_cfg_s;

  typedef enum logic [2:0] {
    G_IDLE = 3'b000, G_PRE = 3'b001, G_DA = 3'b010, G_SA = 3'b011,
    G_LEN  = 3'b100, G_DATA = 3'b101, G_FCS = 3'b110, G_GAP = 3'b111
  } gen_state_e;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ON = 2'b01, S_OFF = 2'b10} stretch_e;

endpackage : phy_test_pkg

/* test/link_partner_model.sv */
`timescale 1ns/1ns
`default_nettype none
module link_partner_model (
  input  wire logic             clk_sys,  // Clock
  output phy_test_pkg::stream_s media_rx  // Bytes to the block
);
  // ****************************************
  // Frame sender
  // ****************************************
  initial media_rx = '0;
  // Idle cycles flip the data so a stale byte never repeats
  task automatic put(input logic [7:0] b, input logic v);
    @(posedge clk_sys);
    #1;
    media_rx = '{en: v, er: 1'b0, data: v ? b : ~media_rx.data};
  endtask : put
  // Preamble, start, counting bytes, check word, idle; no cable loop
  task automatic send_frame(input int n, input logic bad);
    logic [31:0] crc;
    crc = 32'hffffffff;
    for (int i = 0; i < 8; i++) begin
      put(i < 7 ? 8'h55 : 8'hd5, 1'b1);
    end
    for (int i = 0; i < n; i++) begin
      put(8'(i), 1'b1);
      crc = crc ^ 32'(8'(i));
      for (int k = 0; k < 8; k++) begin
        crc = crc[0] ? (crc >> 1) ^ phy_test_pkg::CRC_POLY : crc >> 1;
      end
    end
    // Uninverted check word makes the frame bad
    crc = bad ? crc : ~crc;
    for (int i = 0; i < 8; i++) begin
      put(i < 4 ? crc[8*i +: 8] : 8'h00, i < 4);
    end
  endtask : send_frame
endmodule : link_partner_model
`default_nettype wire

/* test/phy_led_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module phy_led_assertions #(
  parameter int PULSE_CYC = 50  // Prescaler length
) (
  input wire logic                   clk_sys,           // Clock
  input wire logic                   rst,               // Reset
  input wire phy_test_pkg::led_cfg_s led_cfg [4],       // Pin setup
  input wire logic                   led_invert,        // Polarity
  input wire logic                   led_pulsing_en,    // Pulsing
  input wire logic [3:0]             indicator_outputs, // Pins
  input wire phy_test_pkg::stream_s  mac_tx,            // From MAC
  input wire phy_test_pkg::stream_s  mac_rx,            // To MAC
  input wire phy_test_pkg::stream_s  media_rx,          // From partner
  input wire phy_test_pkg::stream_s  media_tx,          // To partner
  input wire logic                   gen_en,            // Generator owns tx
  input wire logic                   gen_run_set,       // Start pulse
  input wire logic                   gen_run,           // Run bit
  input wire logic                   far_loop_en,       // Far loopback
  input wire logic                   dig_loop_en,       // Near loopback
  input wire logic                   rd_good,           // Good read
  input wire logic                   rd_bad,            // Bad read
  input wire logic                   rd_active,         // Active read
  input wire logic [13:0]            good_count,        // Good count
  input wire logic [7:0]             bad_count,         // Bad count
  input wire logic                   count_active       // Active flag
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Pin lags mode by one register
  AST_FORCE_ON: assert property ((led_cfg[0].mode == 4'hf && !led_pulsing_en) [*2] |-> indicator_outputs[0] == led_invert)
    else $error("forced pin not asserted");
  AST_DIG_LOOP: assert property (dig_loop_en |=> !media_tx.en && mac_rx == $past(mac_tx))
    else $error("near loopback path wrong");
  AST_FAR_LOOP: assert property (far_loop_en && !dig_loop_en |=> media_tx == $past(media_rx))
    else $error("far loopback path wrong");
  AST_RX_PASS: assert property (!dig_loop_en |=> mac_rx == $past(media_rx))
    else $error("receive path wrong");
  AST_MAC_PASS: assert property (!gen_en && !far_loop_en && !dig_loop_en |=> media_tx == $past(mac_tx))
    else $error("transmit path wrong");
  AST_GEN_START: assert property (gen_run_set |=> gen_run)
    else $error("run bit not set");
  AST_BAD_SAT: assert property (bad_count == 8'hff && !rd_bad |=> bad_count == 8'hff)
    else $error("bad count left saturation");
  AST_GOOD_STEP: assert property (!$past(rst) && !$past(rd_good) && $changed(good_count) |-> good_count == ($past(good_count) == 14'h270f ? 14'h0 : $past(good_count) + 14'h1))
    else $error("good count stepped wrongly");
  AST_ACTIVE: assert property (count_active && !rd_active |=> count_active)
    else $error("active flag dropped unread");
  cover property (gen_run_set ##[1:3] media_tx.en);
  cover property (bad_count == 8'hff);
  cover property (far_loop_en && media_rx.en);
endmodule : phy_led_assertions
bind phy_led_and_test_logic phy_led_assertions #(.PULSE_CYC(PULSE_CYC)) phy_led_assertions_inst (
  .clk_sys(clk_sys), .rst(rst), .led_cfg(led_cfg), .led_invert(led_invert), .led_pulsing_en(led_pulsing_en),
  .indicator_outputs(indicator_outputs), .mac_tx(mac_tx), .mac_rx(mac_rx), .media_rx(media_rx),
  .media_tx(media_tx), .gen_en(gen_en), .gen_run_set(gen_run_set), .gen_run(gen_run),
  .far_loop_en(far_loop_en), .dig_loop_en(dig_loop_en), .rd_good(rd_good), .rd_bad(rd_bad),
  .rd_active(rd_active), .good_count(good_count), .bad_count(bad_count), .count_active(count_active));
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ****************************************
  // Block, partner and helpers
  // ****************************************
  localparam int MS = 250;  // Cycles per ms at prescaler 50
  logic       clk_sys, rst, led_invert, led_pulsing_en, act_tx_only, link_up, full_duplex, collision, an_fault;
  logic       gen_en, gen_run_set, gen_run_clr, gen_run, far_loop_en, dig_loop_en, rd_good, rd_bad, rd_active;
  logic       count_active;
  logic [1:0] link_speed;
  logic [3:0] indicator_outputs;
  logic [7:0] bad_count;
  logic [13:0] good_count;
  logic [6:0] mode_tbl [6] = '{7'h78, 7'h71, 7'h69, 7'h64, 7'h61, 7'h7b};  // Mode, fault, invert, pin
  phy_test_pkg::led_cfg_s led_cfg [4];
  phy_test_pkg::stream_s  mac_tx, mac_rx, media_rx, media_tx, prev;
  phy_test_pkg::gen_cfg_s gen_cfg;
  int         fail_count = 0, comparisons = 0, n;
  phy_led_and_test_logic #(.PULSE_CYC(50)) phy_led_and_test_logic_inst (
    .clk_sys(clk_sys), .rst(rst), .led_cfg(led_cfg), .led_invert(led_invert), .led_pulsing_en(led_pulsing_en),
    .act_tx_only(act_tx_only), .link_up(link_up), .link_speed(link_speed), .full_duplex(full_duplex),
    .collision(collision), .an_fault(an_fault), .indicator_outputs(indicator_outputs), .mac_tx(mac_tx),
    .mac_rx(mac_rx), .media_rx(media_rx), .media_tx(media_tx), .gen_en(gen_en), .gen_run_set(gen_run_set),
    .gen_run_clr(gen_run_clr), .gen_cfg(gen_cfg), .gen_run(gen_run), .far_loop_en(far_loop_en),
    .dig_loop_en(dig_loop_en), .rd_good(rd_good), .rd_bad(rd_bad), .rd_active(rd_active),
    .good_count(good_count), .bad_count(bad_count), .count_active(count_active));
  link_partner_model link_partner_model_inst (.clk_sys(clk_sys), .media_rx(media_rx));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Value in the pulse cycle, zero after
  task automatic read_cnt(input int which, input logic [15:0] exp);
    step();
    rd_good = (which == 0);
    rd_bad = (which == 1);
    rd_active = (which == 2);
    chk(which == 0 ? 16'(good_count) : which == 1 ? 16'(bad_count) : 16'(count_active), exp, "read");
    step();
    {rd_good, rd_bad, rd_active} = 3'h0;
    chk(which == 0 ? 16'(good_count) : which == 1 ? 16'(bad_count) : 16'(count_active), 16'h0, "clear");
  endtask : read_cnt
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    led_cfg = '{default: '0};
    {led_invert, led_pulsing_en, act_tx_only, link_up, full_duplex, collision, an_fault} = 7'h0;
    {gen_en, gen_run_set, gen_run_clr, far_loop_en, dig_loop_en, rd_good, rd_bad, rd_active} = 8'h0;
    link_speed = 2'h2;
    mac_tx = '0;
    gen_cfg = '0;
    rst = 1'b1;
    step(3);
    chk(16'(indicator_outputs), 16'h000f, "reset pins");
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      led_cfg[0].mode = mode_tbl[i][6:3];
      an_fault = mode_tbl[i][2];
      led_invert = mode_tbl[i][1];
      step(2);
      chk(16'(indicator_outputs[0]), 16'(mode_tbl[i][0]), "mode");
    end
    $display("Test modes done");
    led_invert = 1'b0;
    led_pulsing_en = 1'b1;
    step(2);
    n = 0;
    // Ten whole periods: phase-free
    repeat (500) begin
      step();
      n += int'(indicator_outputs[0] === 1'b0);
    end
    chk(16'(n), 16'h0064, "pulsing");
    led_pulsing_en = 1'b0;
    $display("Test pulsing done");
    link_up = 1'b1;
    led_cfg = '{'{4'ha, 1'b0, 1'b1, 2'h0}, '{4'ha, 1'b0, 1'b1, 2'h1}, '{4'h0, 1'b1, 1'b1, 2'h0}, '{4'he, 1'b0, 1'b0, 2'h0}};
    step(2);
    link_partner_model_inst.send_frame(4, 1'b0);
    step(25 * MS - 20);
    chk(16'(indicator_outputs), 16'h0008, "stretch 25");
    step(50 * MS);
    chk(16'(indicator_outputs), 16'h0009, "stretch 75");
    step(50 * MS);
    chk(16'(indicator_outputs), 16'h000b, "stretch 125");
    $display("Test stretch done");
    mac_tx = '{en: 1'b1, er: 1'b0, data: 8'ha5};
    // Near loopback, far loopback, generator, then the plain path
    for (int i = 0; i < 4; i++) begin
      {gen_en, far_loop_en, dig_loop_en} = 3'(1 << i);
      prev = media_rx;
      step();
      chk(i == 2 ? 16'(media_tx.en) : 16'(media_tx),
          i == 0 || i == 2 ? 16'h0 : i == 1 ? 16'(prev) : 16'h02a5, "tx");
      chk(16'(mac_rx), i == 0 ? 16'h02a5 : 16'(prev), "rx");
    end
    far_loop_en = 1'b1;
    fork
      link_partner_model_inst.send_frame(6, 1'b0);
      repeat (24) begin
        @(negedge clk_sys) prev = media_rx;
        step();
        chk(16'(media_tx), 16'(prev), "far tx");
        chk(16'(mac_rx), 16'(prev), "far rx");
      end
    join
    $display("Test paths done");
    far_loop_en = 1'b0;
    gen_cfg.dst_addr = 48'h0a0b0c0d0e0f;
    gen_cfg.size = 12'h004;
    gen_en = 1'b1;
    gen_run_set = 1'b1;
    step();
    gen_run_set = 1'b0;
    chk(16'(gen_run), 16'h0001, "run");
    n = 0;
    while (media_tx.en !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    for (int k = 0; k < 9; k++) begin
      chk(16'(media_tx), {8'h02, k < 7 ? 8'h55 : k == 7 ? 8'hd5 : 8'h0a}, "gen");
      step();
    end
    gen_run_clr = 1'b1;
    step();
    gen_run_clr = 1'b0;
    chk(16'(gen_run), 16'h0, "stop");
    gen_en = 1'b0;
    mac_tx = '0;
    $display("Test generator done");
    read_cnt(0, 16'h0002);
    read_cnt(2, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      link_partner_model_inst.send_frame(4, i > 2);
    end
    read_cnt(0, 16'h0003);
    read_cnt(2, 16'h0001);
    repeat (257) link_partner_model_inst.send_frame(3, 1'b1);
    read_cnt(1, 16'h00ff);
    read_cnt(0, 16'h0);
    $display("Test counters done");
    end_of_test();
  end
  // Hang guard, about twice the run
  initial begin
    step(80000);
    fail_count++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
